// File: hdl/rtc_core.v
// real-time clock core: time counters, alarms, periodic interrupt and flags
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.vh"
module rtc_core #(
  parameter EDGES_PER_SEC = `TB_EDGES_PER_SEC
) (
  input  wire               mclk,          // core clock, 125 MHz
  input  wire               srst,          // synchronous reset, active high
  input  wire [`ADDR_W-1:0] addr,          // register address
  input  wire [`DATA_W-1:0] wdata,         // write data
  input  wire               wr,            // write strobe
  input  wire               rd,            // read strobe
  output reg  [`DATA_W-1:0] rdata,         // read data, cycle after rd
  input  wire               tb_clk,        // timebase clock pin
  input  wire               backup_resume, // strap: supply came back from battery
  input  wire               vdd_low,       // supply monitor below threshold
  output reg                irq_a_out,     // interrupt pin output value
  output reg                irq_a_oe_n,    // interrupt pin enable, low = pull low
  output reg                irq            // level interrupt to the system
);
  // divider limits are cut to the divider's width on purpose
  localparam integer      EDGES_M1 = EDGES_PER_SEC - 1;
  localparam integer      EDGES_H  = EDGES_PER_SEC / 2;
  localparam integer      EDGES_Q  = EDGES_PER_SEC / 4;
  localparam [`PRE_W-1:0] PRE_TOP  = EDGES_M1[`PRE_W-1:0];
  localparam [`PRE_W-1:0] PRE_HALF = EDGES_H[`PRE_W-1:0];
  localparam [`PRE_W-1:0] PRE_QTR  = EDGES_Q[`PRE_W-1:0];
  localparam [`PRE_W-1:0] PRE_3QTR = PRE_HALF + PRE_QTR;

  // pin synchronisers
  reg        tb_s1;
  reg        tb_s2;
  reg        tb_s3;
  reg        bk_s1;
  reg        bk_s2;
  reg        vl_s1;
  reg        vl_s2;
  // the timebase flops take no reset: clearing them would fake a rising
  // edge just after reset whenever the pin happens to be high
  always @(posedge mclk) begin
    tb_s1 <= tb_clk;
    tb_s2 <= tb_s1;
    tb_s3 <= tb_s2;
  end
  always @(posedge mclk) begin
    if (srst) begin
      bk_s1 <= 1'b0;
      bk_s2 <= 1'b0;
      vl_s1 <= 1'b0;
      vl_s2 <= 1'b0;
    end else begin
      bk_s1 <= backup_resume;
      bk_s2 <= bk_s1;
      vl_s1 <= vdd_low;
      vl_s2 <= vl_s1;
    end
  end
  wire tb_edge = tb_s2 && !tb_s3;

  // register decode
  wire wr_sec   = wr && (addr == `A_SEC);
  wire wr_min   = wr && (addr == `A_MIN);
  wire wr_hour  = wr && (addr == `A_HOUR);
  wire wr_wday  = wr && (addr == `A_WDAY);
  wire wr_day   = wr && (addr == `A_DAY);
  wire wr_month = wr && (addr == `A_MONTH);
  wire wr_year  = wr && (addr == `A_YEAR);
  wire wr_c1    = wr && (addr == `A_CTRL1);
  wire wr_c2    = wr && (addr == `A_CTRL2);

  // sub-second divider
  reg  [`PRE_W-1:0] pre;
  wire              sec_tick = tb_edge && (pre == PRE_TOP) && !wr_sec;
  always @(posedge mclk) begin
    if (srst) begin
      pre <= {`PRE_W{1'b0}};
    end else if (wr_sec) begin
      pre <= {`PRE_W{1'b0}};
    end else if (tb_edge) begin
      pre <= (pre == PRE_TOP) ? {`PRE_W{1'b0}} : pre + {{(`PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // time and calendar counters
  wire [`CNT_W-1:0] sec_v;
  wire [`CNT_W-1:0] min_v;
  wire [`CNT_W-1:0] hour_v;
  wire [`CNT_W-1:0] wday_v;
  wire [`CNT_W-1:0] day_v;
  wire [`CNT_W-1:0] month_v;
  wire [`CNT_W-1:0] year_v;
  wire              sec_c;
  wire              min_c;
  wire              hour_c;
  wire              day_c;
  wire              month_c;
  reg  [`CNT_W-1:0] day_top;

  // two-digit years: every fourth year is a leap year
  always @* begin
    if (month_v == `M_FEB) begin
      day_top = (year_v[1:0] == 2'b00) ? `DAYS_29 : `DAYS_28;
    end else if ((month_v == `M_APR) || (month_v == `M_JUN) ||
                 (month_v == `M_SEP) || (month_v == `M_NOV)) begin
      day_top = `DAYS_30;
    end else begin
      day_top = `DAYS_31;
    end
  end

  wrap_counter #(.W(`CNT_W), .LOW(`ZERO_LOW), .RST(`ZERO_LOW)) u_sec (
    .mclk(mclk), .srst(srst), .load(wr_sec), .load_val(wdata[`CNT_W-1:0]),
    .inc(sec_tick), .top(`SEC_TOP), .value(sec_v), .carry(sec_c));
  wrap_counter #(.W(`CNT_W), .LOW(`ZERO_LOW), .RST(`ZERO_LOW)) u_min (
    .mclk(mclk), .srst(srst), .load(wr_min), .load_val(wdata[`CNT_W-1:0]),
    .inc(sec_c), .top(`MIN_TOP), .value(min_v), .carry(min_c));
  wrap_counter #(.W(`CNT_W), .LOW(`ZERO_LOW), .RST(`ZERO_LOW)) u_hour (
    .mclk(mclk), .srst(srst), .load(wr_hour), .load_val(wdata[`CNT_W-1:0]),
    .inc(min_c), .top(`HOUR_TOP), .value(hour_v), .carry(hour_c));
  wrap_counter #(.W(`CNT_W), .LOW(`ZERO_LOW), .RST(`ZERO_LOW)) u_wday (
    .mclk(mclk), .srst(srst), .load(wr_wday), .load_val(wdata[`CNT_W-1:0]),
    .inc(hour_c), .top(`WDAY_TOP), .value(wday_v), .carry());
  wrap_counter #(.W(`CNT_W), .LOW(`ONE_LOW), .RST(`ONE_LOW)) u_day (
    .mclk(mclk), .srst(srst), .load(wr_day), .load_val(wdata[`CNT_W-1:0]),
    .inc(hour_c), .top(day_top), .value(day_v), .carry(day_c));
  wrap_counter #(.W(`CNT_W), .LOW(`ONE_LOW), .RST(`ONE_LOW)) u_month (
    .mclk(mclk), .srst(srst), .load(wr_month), .load_val(wdata[`CNT_W-1:0]),
    .inc(day_c), .top(`MONTH_TOP), .value(month_v), .carry(month_c));
  wrap_counter #(.W(`CNT_W), .LOW(`ZERO_LOW), .RST(`ZERO_LOW)) u_year (
    .mclk(mclk), .srst(srst), .load(wr_year), .load_val(wdata[`CNT_W-1:0]),
    .inc(month_c), .top(`YEAR_TOP), .value(year_v), .carry());

  // alarm and control registers
  reg [`DATA_W-1:0] alw_min;
  reg [`DATA_W-1:0] alw_hour;
  reg [`DATA_W-1:0] alw_wday;
  reg [`DATA_W-1:0] ald_min;
  reg [`DATA_W-1:0] ald_hour;
  reg               weekly_alarm_enable;
  reg               daily_alarm_enable;
  reg [2:0]         periodic_select_field;
  always @(posedge mclk) begin
    if (srst) begin
      alw_min               <= 8'h00;
      alw_hour              <= 8'h00;
      alw_wday              <= 8'h00;
      ald_min               <= 8'h00;
      ald_hour              <= 8'h00;
      weekly_alarm_enable   <= 1'b0;
      daily_alarm_enable    <= 1'b0;
      periodic_select_field <= `SEL_OFF;
    end else if (wr) begin
      case (addr)
        `A_ALW_MIN:  alw_min  <= wdata;
        `A_ALW_HOUR: alw_hour <= wdata;
        `A_ALW_WDAY: alw_wday <= wdata;
        `A_ALD_MIN:  ald_min  <= wdata;
        `A_ALD_HOUR: ald_hour <= wdata;
        `A_CTRL1: begin
          weekly_alarm_enable   <= wdata[`C1_WAEN];
          daily_alarm_enable    <= wdata[`C1_DAEN];
          periodic_select_field <= wdata[`C1_SEL_HI:`C1_SEL_LO];
        end
        default: ;
      endcase
    end
  end

  // alarms compare the minute and hour bytes whole, and test the weekday byte as a bit mask,
  // once each new minute; a minute or hour byte with bits that no counter ever holds can
  // never match, which is how alarms are cancelled
  reg  minute_new;
  always @(posedge mclk) begin
    if (srst) begin
      minute_new <= 1'b0;
    end else begin
      minute_new <= sec_c;
    end
  end
  wire [`DATA_W-1:0] min_b  = {1'b0, min_v};
  wire [`DATA_W-1:0] hour_b = {1'b0, hour_v};
  wire walarm_hit = minute_new && weekly_alarm_enable && (alw_min == min_b) &&
                    (alw_hour == hour_b) && alw_wday[wday_v[2:0]];
  wire dalarm_hit = minute_new && daily_alarm_enable && (ald_min == min_b) &&
                    (ald_hour == hour_b);

  // periodic level-mode events
  reg per_hit;
  always @* begin
    case (periodic_select_field)
      `SEL_SEC:   per_hit = sec_tick;
      `SEL_MIN:   per_hit = sec_c;
      `SEL_HOUR:  per_hit = min_c;
      `SEL_MONTH: per_hit = day_c;
      default:    per_hit = 1'b0;
    endcase
  end

  // status flags; an event in the cycle of a clearing write wins
  reg       periodic_irq_flag;
  reg       weekly_alarm_flag;
  reg       daily_alarm_flag;
  reg       voltage_drop_flag;
  reg       cold_start_flag;
  reg [1:0] strap_cnt;
  wire clr_per  = wr_c2 && !wdata[`C2_PFLAG];
  wire clr_wal  = wr_c2 && !wdata[`C2_WAFLAG];
  wire clr_dal  = wr_c2 && !wdata[`C2_DAFLAG];
  wire clr_vd   = wr_c2 && !wdata[`C2_VDROP];
  wire clr_cold = wr_c2 && !wdata[`C2_COLD];
  always @(posedge mclk) begin
    if (srst) begin
      periodic_irq_flag <= 1'b0;
      weekly_alarm_flag <= 1'b0;
      daily_alarm_flag  <= 1'b0;
      voltage_drop_flag <= 1'b0;
      cold_start_flag   <= 1'b1;
      strap_cnt         <= 2'h0;
    end else begin
      periodic_irq_flag <= per_hit || (periodic_irq_flag && !clr_per);
      // writing one keeps a flag; writing zero leaves the enables alone
      weekly_alarm_flag <= walarm_hit || (weekly_alarm_flag && !clr_wal);
      daily_alarm_flag  <= dalarm_hit || (daily_alarm_flag && !clr_dal);
      voltage_drop_flag <= vl_s2 || (voltage_drop_flag && !clr_vd);
      // the strap is caught once the synchroniser has settled
      if (strap_cnt != `STRAP_WAIT) begin
        strap_cnt <= strap_cnt + 2'h1;
        if (strap_cnt == `STRAP_WAIT - 2'h1) begin
          cold_start_flag <= !bk_s2;
        end
      end else if (clr_cold) begin
        cold_start_flag <= 1'b0;
      end
    end
  end

  // interrupt pin: open drain, low while the periodic select or either alarm flag asserts
  reg pin_low;
  always @* begin
    case (periodic_select_field)
      `SEL_OFF: pin_low = 1'b0;
      `SEL_LOW: pin_low = 1'b1;
      `SEL_2HZ: pin_low = (pre < PRE_QTR) || ((pre >= PRE_HALF) && (pre < PRE_3QTR));
      `SEL_1HZ: pin_low = (pre < PRE_HALF);
      default:  pin_low = periodic_irq_flag;
    endcase
  end
  always @(posedge mclk) begin
    if (srst) begin
      irq_a_out  <= 1'b0;
      irq_a_oe_n <= 1'b1;
    end else begin
      irq_a_out  <= 1'b0;
      irq_a_oe_n <= !(pin_low || weekly_alarm_flag || daily_alarm_flag);
    end
  end

  // system interrupt: sticky status, write-one clear, enable mask
  wire [`IS_W-1:0] int_ev;
  reg  [`IS_W-1:0] int_status;
  reg  [`IS_W-1:0] int_enable;
  assign int_ev[`IS_SEC]   = sec_tick;
  assign int_ev[`IS_PER]   = per_hit;
  assign int_ev[`IS_WAL]   = walarm_hit;
  assign int_ev[`IS_DAL]   = dalarm_hit;
  assign int_ev[`IS_VDROP] = vl_s2 && !voltage_drop_flag;
  wire [`IS_W-1:0] int_clr = (wr && (addr == `A_INT_CLEAR)) ? wdata[`IS_W-1:0]
                                                             : {`IS_W{1'b0}};
  always @(posedge mclk) begin
    if (srst) begin
      int_status <= {`IS_W{1'b0}};
      int_enable <= {`IS_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      int_status <= int_ev | (int_status & ~int_clr);
      if (wr && (addr == `A_INT_ENABLE)) begin
        int_enable <= wdata[`IS_W-1:0];
      end
      irq <= |(int_status & int_enable);
    end
  end

  // read port: data stand for exactly one cycle after the strobe
  reg [`DATA_W-1:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    case (addr)
      `A_SEC:        next_rdata = {1'b0, sec_v};
      `A_MIN:        next_rdata = min_b;
      `A_HOUR:       next_rdata = hour_b;
      `A_WDAY:       next_rdata = {1'b0, wday_v};
      `A_DAY:        next_rdata = {1'b0, day_v};
      `A_MONTH:      next_rdata = {1'b0, month_v};
      `A_YEAR:       next_rdata = {1'b0, year_v};
      `A_ALW_MIN:    next_rdata = alw_min;
      `A_ALW_HOUR:   next_rdata = alw_hour;
      `A_ALW_WDAY:   next_rdata = alw_wday;
      `A_ALD_MIN:    next_rdata = ald_min;
      `A_ALD_HOUR:   next_rdata = ald_hour;
      `A_CTRL1: begin
        next_rdata[`C1_WAEN]             = weekly_alarm_enable;
        next_rdata[`C1_DAEN]             = daily_alarm_enable;
        next_rdata[`C1_SEL_HI:`C1_SEL_LO] = periodic_select_field;
      end
      `A_CTRL2: begin
        next_rdata[`C2_VDROP]  = voltage_drop_flag;
        next_rdata[`C2_COLD]   = cold_start_flag;
        next_rdata[`C2_PFLAG]  = periodic_irq_flag;
        next_rdata[`C2_WAFLAG] = weekly_alarm_flag;
        next_rdata[`C2_DAFLAG] = daily_alarm_flag;
      end
      `A_INT_STATUS: next_rdata = {3'h0, int_status};
      `A_INT_ENABLE: next_rdata = {3'h0, int_enable};
      default:       next_rdata = 8'h00;
    endcase
  end
  always @(posedge mclk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end
endmodule // rtc_core
`default_nettype wire

// File: shared/rtc_map.vh
// register map, field positions and timing constants of the real-time clock core
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

`define ADDR_W          5
`define DATA_W          8
`define CNT_W           7

`define A_SEC           5'h00
`define A_MIN           5'h01
`define A_HOUR          5'h02
`define A_WDAY          5'h03
`define A_DAY           5'h04
`define A_MONTH         5'h05
`define A_YEAR          5'h06
`define A_ALW_MIN       5'h08
`define A_ALW_HOUR      5'h09
`define A_ALW_WDAY      5'h0A
`define A_ALD_MIN       5'h0B
`define A_ALD_HOUR      5'h0C
`define A_CTRL1         5'h0E
`define A_CTRL2         5'h0F
`define A_INT_STATUS    5'h10
`define A_INT_CLEAR     5'h11
`define A_INT_ENABLE    5'h12

// control 1 fields
`define C1_WAEN         7
`define C1_DAEN         6
`define C1_SEL_HI       2
`define C1_SEL_LO       0
// control 2 fields
`define C2_VDROP        6
`define C2_COLD         4
`define C2_PFLAG        2
`define C2_WAFLAG       1
`define C2_DAFLAG       0

// interrupt status bits
`define IS_W            5
`define IS_SEC          0
`define IS_PER          1
`define IS_WAL          2
`define IS_DAL          3
`define IS_VDROP        4

// periodic select codes
`define SEL_OFF         3'h0
`define SEL_LOW         3'h1
`define SEL_2HZ         3'h2
`define SEL_1HZ         3'h3
`define SEL_SEC         3'h4
`define SEL_MIN         3'h5
`define SEL_HOUR        3'h6
`define SEL_MONTH       3'h7

// counter ranges
`define SEC_TOP         7'h3B
`define MIN_TOP         7'h3B
`define HOUR_TOP        7'h17
`define WDAY_TOP        7'h06
`define MONTH_TOP       7'h0C
`define YEAR_TOP        7'h63
`define ZERO_LOW        7'h00
`define ONE_LOW         7'h01
`define DAYS_31         7'h1F
`define DAYS_30         7'h1E
`define DAYS_29         7'h1D
`define DAYS_28         7'h1C
`define M_FEB           7'h02
`define M_APR           7'h04
`define M_JUN           7'h06
`define M_SEP           7'h09
`define M_NOV           7'h0B

// timebase edges per second and synchroniser settle time
`define TB_EDGES_PER_SEC 32768
`define PRE_W           15
`define STRAP_WAIT      2'h3

`endif

// File: hdl/wrap_counter.v
// loadable counter that wraps from a top value back to a low value
`timescale 1ns/1ps
`default_nettype none
module wrap_counter #(
  parameter          W   = 7,
  parameter [W-1:0]  LOW = 7'h00,
  parameter [W-1:0]  RST = 7'h00
) (
  input  wire         mclk,      // core clock
  input  wire         srst,      // synchronous reset
  input  wire         load,      // software write
  input  wire [W-1:0] load_val,  // written value
  input  wire         inc,       // count enable
  input  wire [W-1:0] top,       // last value before wrap
  output reg  [W-1:0] value,     // current count
  output wire         carry      // wrap in this cycle
);
  // a load in the same cycle as a carry wins and suppresses the carry
  assign carry = inc && !load && (value >= top);

  always @(posedge mclk) begin
    if (srst) begin
      value <= RST;
    end else if (load) begin
      value <= load_val;
    end else if (inc) begin
      value <= (value >= top) ? LOW : value + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // wrap_counter
`default_nettype wire

// File: verif/rtc_core_checker.sv
// port assertions for the real-time clock core
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.vh"
module rtc_core_checker #(
  parameter EDGES_PER_SEC = 8
) (
  input wire logic               mclk,          // core clock
  input wire logic               srst,          // synchronous reset
  input wire logic [`ADDR_W-1:0] addr,          // register address
  input wire logic [`DATA_W-1:0] wdata,         // write data
  input wire logic               wr,            // write strobe
  input wire logic               rd,            // read strobe
  input wire logic [`DATA_W-1:0] rdata,         // read data
  input wire logic               tb_clk,        // timebase pin
  input wire logic               backup_resume, // supply strap
  input wire logic               vdd_low,       // supply monitor
  input wire logic               irq_a_out,     // pin value
  input wire logic               irq_a_oe_n,    // pin enable
  input wire logic               irq            // system interrupt
);
  logic [7:0] ctl1;
  logic [4:0] ien;
  wire        ctl2_wr = wr && (addr == `A_CTRL2);
  // pulse modes toggle the pin on their own, so holding checks skip them
  wire        pulsed  = (ctl1[2:0] == `SEL_2HZ) || (ctl1[2:0] == `SEL_1HZ);
  always @(posedge mclk) begin
    if (srst) begin
      ctl1 <= 8'h00;
      ien  <= 5'h00;
    end else begin
      if (wr && addr == `A_CTRL1) ctl1 <= wdata;
      if (wr && addr == `A_INT_ENABLE) ien <= wdata[4:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_read_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_refused_read: assert property (rd && (addr == 5'h07 || addr == `A_INT_CLEAR) |=> rdata == 8'h00)
    else $error("unmapped or clear register read not zero");
  a_counter_bit7: assert property (rd && addr <= `A_YEAR |=> !rdata[7])
    else $error("counter read with bit 7 set");
  a_pin_only_low: assert property (irq_a_out == 1'b0)
    else $error("interrupt pin driven high");
  a_level_holds_low: assert property (
    !irq_a_oe_n && !pulsed && !wr && !$past(wr) |=> !irq_a_oe_n)
    else $error("level interrupt released without flag write");
  a_flag_release: assert property (
    ctl2_wr && wdata[2:0] == 3'h0 && ctl1[2] |-> ##2 irq_a_oe_n)
    else $error("pin not released after flag write of zero");
  a_flag_one_keeps: assert property (
    ctl2_wr && wdata[2:0] == 3'h7 && !irq_a_oe_n && !pulsed |=> ##1 !irq_a_oe_n)
    else $error("writing one to flags released the pin");
  a_irq_masked: assert property (ien == 5'h00 && $past(ien) == 5'h00 |-> !irq)
    else $error("system interrupt high with all sources masked");
  c_level_low: cover property (!irq_a_oe_n && ctl1[2]);
  c_irq_rise: cover property ($rose(irq));
  c_flag_keep: cover property (ctl2_wr && wdata[2:0] == 3'h7 && !irq_a_oe_n);
endmodule // rtc_core_checker
`default_nettype wire
bind rtc_core rtc_core_checker #(.EDGES_PER_SEC(EDGES_PER_SEC)) chk (
  .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .tb_clk(tb_clk), .backup_resume(backup_resume), .vdd_low(vdd_low),
  .irq_a_out(irq_a_out), .irq_a_oe_n(irq_a_oe_n), .irq(irq));

// File: verif/timebase_src.sv
// free-running timebase crystal and pulled-up interrupt line
`timescale 1ns/1ps
`default_nettype none
module timebase_src (
  output var logic tb_clk,     // timebase clock, 125 ns period
  input wire logic irq_a_out,  // pin value from the core
  input wire logic irq_a_oe_n, // pin enable, low = driven
  output wire logic irq_pin    // resolved line level
);
  // the crystal never stops, so the timebase clock runs free
  initial begin
    tb_clk = 1'b0;
    forever #62.5 tb_clk = ~tb_clk;
  end
  // open drain: a released line rises through its pull-up
  assign irq_pin = irq_a_oe_n ? 1'b1 : irq_a_out;
endmodule // timebase_src
`default_nettype wire

// File: verif/test_rtc_core.sv
// self-checking bench for the real-time clock core
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.vh"
module test_rtc_core;
  logic       mclk;
  logic       srst;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       backup_resume;
  logic       vdd_low;
  wire  [7:0] rdata;
  wire        tb_clk;
  wire        irq_a_out;
  wire        irq_a_oe_n;
  wire        irq;
  wire        irq_pin;
  logic [7:0] rv;
  int         failures = 0;
  int         cmp_count = 0;
  int         cycles = 0;

  rtc_core #(.EDGES_PER_SEC(8)) DUT (
    .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tb_clk(tb_clk), .backup_resume(backup_resume), .vdd_low(vdd_low),
    .irq_a_out(irq_a_out), .irq_a_oe_n(irq_a_oe_n), .irq(irq));
  timebase_src tbs (.tb_clk(tb_clk), .irq_a_out(irq_a_out), .irq_a_oe_n(irq_a_oe_n),
    .irq_pin(irq_pin));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic wait_pin(input logic lvl, input int lim);
    int n;
    n = 0;
    while (irq_pin !== lvl && n < lim) begin
      @(posedge mclk);
      n++;
    end
    check({7'h00, irq_pin}, {7'h00, lvl});
  endtask

  task automatic do_reset(input logic strap);
    @(posedge mclk);
    srst          <= 1'b1;
    backup_resume <= strap;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // all counters go in one unbroken run of writes, far inside half a second
  task automatic set_time(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
    wr_reg(`A_SEC, s);
    wr_reg(`A_MIN, m);
    wr_reg(`A_HOUR, h);
    wr_reg(`A_WDAY, 8'h00);
    wr_reg(`A_DAY, 8'h01);
    wr_reg(`A_MONTH, 8'h01);
    wr_reg(`A_YEAR, 8'h00);
  endtask

  task automatic t_power_on;
    do_reset(1'b0);
    repeat (100) @(posedge mclk);
    rd_reg(`A_CTRL2);
    check({7'h00, rv[`C2_COLD]}, 8'h01);
    rd_reg(`A_DAY);
    check(rv, 8'h01);
    do_reset(1'b1);
    rd_reg(`A_CTRL2);
    check({7'h00, rv[`C2_COLD]}, 8'h00);
    rd_reg(5'h07);
    check(rv, 8'h00);
  endtask

  task automatic t_time_write;
    @(posedge mclk);
    vdd_low <= 1'b1;
    repeat (10) @(posedge mclk);
    vdd_low <= 1'b0;
    set_time(8'h01, 8'h02, 8'h03);
    wr_reg(`A_CTRL2, 8'h00);
    rd_reg(`A_CTRL2);
    check({7'h00, rv[`C2_VDROP]}, 8'h00);
    rd_reg(`A_SEC);
    check(rv, 8'h01);
    // write mid-phase so no timebase edge lands on the write itself
    @(negedge tb_clk);
    wr_reg(`A_SEC, 8'h05);
    repeat (7) @(posedge tb_clk);
    repeat (5) @(posedge mclk);
    rd_reg(`A_SEC);
    check(rv, 8'h05);
    @(posedge tb_clk);
    repeat (5) @(posedge mclk);
    rd_reg(`A_SEC);
    check(rv, 8'h06);
  endtask

  task automatic t_periodic;
    wr_reg(`A_INT_ENABLE, 8'h02);
    wr_reg(`A_CTRL1, {5'h00, `SEL_SEC});
    wait_pin(1'b0, 200);
    rd_reg(`A_SEC);
    check({7'h00, irq}, 8'h01);
    repeat (20) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h00);
    wr_reg(`A_CTRL2, 8'h00);
    repeat (3) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h01);
    wr_reg(`A_INT_ENABLE, 8'h00);
    wr_reg(`A_INT_CLEAR, 8'h1F);
    wait_pin(1'b0, 200);
    rd_reg(`A_SEC);
    check({7'h00, irq}, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr_reg(`A_CTRL1, s[7:0]);
      repeat (130) @(posedge mclk);
    end
    // 1 Hz pulse mode: low for the first half of each second
    wr_reg(`A_CTRL1, {5'h00, `SEL_1HZ});
    @(negedge tb_clk);
    wr_reg(`A_SEC, 8'h00);
    repeat (3) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h00);
    repeat (4) @(posedge tb_clk);
    repeat (5) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h01);
    repeat (4) @(posedge tb_clk);
    repeat (5) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h00);
    wr_reg(`A_CTRL1, {5'h00, `SEL_LOW});
    repeat (3) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h00);
    wr_reg(`A_CTRL1, {5'h00, `SEL_OFF});
    wr_reg(`A_CTRL2, 8'h00);
    repeat (3) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h01);
  endtask

  task automatic t_alarm;
    wr_reg(`A_CTRL1, 8'h00);
    wr_reg(`A_ALW_MIN, 8'h06);
    wr_reg(`A_ALW_HOUR, 8'h01);
    wr_reg(`A_ALW_WDAY, 8'h01);
    wr_reg(`A_ALD_MIN, 8'h06);
    wr_reg(`A_ALD_HOUR, 8'h01);
    wr_reg(`A_CTRL1, 8'hC0);
    wr_reg(`A_INT_ENABLE, 8'h0C);
    set_time(8'h3A, 8'h05, 8'h01);
    wait_pin(1'b0, 400);
    check({7'h00, irq}, 8'h01);
    wr_reg(`A_CTRL2, 8'h07);
    repeat (3) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h00);
    rd_reg(`A_CTRL2);
    check(rv, 8'h03);
    wr_reg(`A_CTRL2, 8'h00);
    repeat (3) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h01);
    rd_reg(`A_CTRL1);
    check(rv, 8'hC0);
    wr_reg(`A_CTRL1, 8'h00);
    for (int a = 0; a < 5; a++) begin
      wr_reg(`A_ALW_MIN + a[4:0], (a < 3) ? 8'hFD : 8'hFE);
    end
    wr_reg(`A_CTRL1, 8'hC0);
    set_time(8'h3A, 8'h05, 8'h01);
    repeat (300) @(posedge mclk);
    check({7'h00, irq_pin}, 8'h01);
  endtask

  initial begin
    srst          = 1'b1;
    addr          = 5'h00;
    wdata         = 8'h00;
    wr            = 1'b0;
    rd            = 1'b0;
    backup_resume = 1'b0;
    vdd_low       = 1'b0;
    t_power_on();
    t_time_write();
    t_periodic();
    t_alarm();
    tally_and_finish();
  end
endmodule // test_rtc_core
`default_nettype wire
